// ===== msm_top.v
`include "msm_map.vh"

module msm_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire [9:0]  angle_in,
    input  wire        angle_valid,
    input  wire [15:0] speed_in,
    output reg  [15:0] speed_out,
    output wire [11:0] cyl_active,
    output wire        seq_running
);

    // ****************************************
    // storage
    // ****************************************
    reg [31:0] cfg_reg [0:11];
    reg [13:0] prob_reg [0:11];
    reg [31:0] seq_reg [0:12];
    reg [11:0] prof_reg [0:63];
    reg [9:0]  ref_reg;
    reg        play_reg;
    reg        trig_reg;
    reg        trig_prev_reg;
    reg [5:0]  seqlen_reg;
    reg [4:0]  step_reg;
    reg        run_reg;
    reg [9:0]  ang_prev_reg;
    reg [31:0] rdata_next;
    reg        err_next;
    integer    i;

    wire [767:0] prof_flat;
    wire [31:0]  rnd;
    wire [11:0]  factor [0:11];
    wire [15:0]  acc [0:12];
    wire [11:0]  seq_bits;
    wire         trig_edge;
    wire         period_start;
    wire         wr;
    wire         setup;
    wire [3:0]   widx;
    wire [5:0]   page;
    wire         hit_cfg;
    wire         hit_prob;
    wire         hit_seq;
    wire         hit_prof;
    wire [31:0]  speed_prod;
    wire [15:0]  speed_sat;

    // ****************************************
    // value limiting on write
    // ****************************************
    function [11:0] clamp_fact;
        input [31:0] v;
        begin
            if (v < {20'h0_0000, `MSM_FACT_MIN}) begin
                clamp_fact = `MSM_FACT_MIN;
            end else if (v > {20'h0_0000, `MSM_FACT_MAX}) begin
                clamp_fact = `MSM_FACT_MAX;
            end else begin
                clamp_fact = v[11:0];
            end
        end
    endfunction

    function [9:0] clamp_ang;
        input [15:0] v;
        begin
            if (v > {6'h00, `MSM_ANG_MAX}) begin
                clamp_ang = `MSM_ANG_MAX;
            end else begin
                clamp_ang = v[9:0];
            end
        end
    endfunction

    function [31:0] clamp_cfg;
        input [31:0] v;
        reg [10:0] att;
        begin
            att = v[26:16];
            if (att > `MSM_ATT_MAX) begin
                att = `MSM_ATT_MAX;
            end
            clamp_cfg = {5'h00, att, 1'b0, v[14:10], clamp_ang({6'h00, v[9:0]})};
        end
    endfunction

    function [13:0] clamp_prob;
        input [31:0] v;
        begin
            if (v > {18'h0_0000, `MSM_PROB_MAX}) begin
                clamp_prob = `MSM_PROB_MAX;
            end else begin
                clamp_prob = v[13:0];
            end
        end
    endfunction

    function [5:0] clamp_len;
        input [31:0] v;
        begin
            if (v == 32'h0000_0000) begin
                clamp_len = 6'h01;
            end else if (v > {26'h000_0000, `MSM_SEQLEN_MAX}) begin
                clamp_len = `MSM_SEQLEN_MAX;
            end else begin
                clamp_len = v[5:0];
            end
        end
    endfunction

    function [15:0] sat16;
        input [21:0] v;
        begin
            if (v[21:16] != 6'h00) begin
                sat16 = 16'hFFFF;
            end else begin
                sat16 = v[15:0];
            end
        end
    endfunction

    // ****************************************
    // apb decode
    // ****************************************
    assign pready = ce;
    assign setup = psel & ~penable & ce;
    assign wr = psel & penable & pwrite & ce;
    assign widx = paddr[5:2];
    assign page = paddr[11:6];
    assign hit_cfg = (page == `MSM_PAGE_CFG) && (widx < 4'hC);
    assign hit_prob = (page == `MSM_PAGE_PROB) && (widx < 4'hC);
    assign hit_seq = (page == `MSM_PAGE_SEQ) && (widx < 4'hD);
    assign hit_prof = (paddr[11:8] == `MSM_PAGE_PROF);

    always @* begin
        rdata_next = 32'h0000_0000;
        err_next = 1'b0;
        if (hit_cfg) begin
            rdata_next = cfg_reg[widx];
        end else if (hit_prob) begin
            rdata_next = {18'h0_0000, prob_reg[widx]};
        end else if (hit_seq) begin
            rdata_next = seq_reg[widx];
        end else if (hit_prof) begin
            rdata_next = {20'h0_0000, prof_reg[paddr[7:2]]};
        end else begin
            case (paddr)
                `MSM_OFF_CTRL: begin
                    rdata_next = {14'h0000, trig_reg, play_reg, 6'h00, ref_reg};
                end
                `MSM_OFF_SEQLEN: begin
                    rdata_next = {26'h000_0000, seqlen_reg};
                end
                `MSM_OFF_STATUS: begin
                    rdata_next = {7'h00, run_reg, 3'h0, step_reg, 4'h0, cyl_active};
                end
                `MSM_OFF_SPEED: begin
                    rdata_next = {16'h0000, speed_out};
                end
                default: begin
                    err_next = 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // register file, all fields writable while running
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `MSM_NCYL; i = i + 1) begin
                cfg_reg[i] <= `MSM_CFG_RST;
                prob_reg[i] <= 14'h0000;
            end
            for (i = 0; i < `MSM_NSEQ; i = i + 1) begin
                seq_reg[i] <= 32'h0000_0000;
            end
            for (i = 0; i < `MSM_PROF_WORDS; i = i + 1) begin
                prof_reg[i] <= `MSM_FP_ONE;
            end
            ref_reg <= 10'h000;
            play_reg <= 1'b0;
            trig_reg <= 1'b0;
            seqlen_reg <= `MSM_SEQLEN_MAX;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_next;
                pslverr <= err_next;
            end
            if (wr) begin
                if (hit_cfg) begin
                    cfg_reg[widx] <= clamp_cfg(pwdata);
                end else if (hit_prob) begin
                    prob_reg[widx] <= clamp_prob(pwdata);
                end else if (hit_seq) begin
                    seq_reg[widx] <= pwdata;
                end else if (hit_prof) begin
                    prof_reg[paddr[7:2]] <= clamp_fact(pwdata);
                end else if (paddr == `MSM_OFF_CTRL) begin
                    ref_reg <= clamp_ang(pwdata[15:0]);
                    play_reg <= pwdata[`MSM_CTRL_PLAY];
                    trig_reg <= pwdata[`MSM_CTRL_TRIG];
                end else if (paddr == `MSM_OFF_SEQLEN) begin
                    seqlen_reg <= clamp_len(pwdata);
                end
            end
        end
    end

    // ****************************************
    // period detect and sequence playback
    // ****************************************
    assign period_start = angle_valid && (angle_in < ang_prev_reg);
    assign trig_edge = trig_reg & ~trig_prev_reg;
    assign seq_running = run_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_reg <= 1'b0;
            run_reg <= 1'b0;
            step_reg <= 5'h00;
            ang_prev_reg <= 10'h000;
        end else if (ce) begin
            trig_prev_reg <= trig_reg;
            if (angle_valid) begin
                ang_prev_reg <= angle_in;
            end
            if (trig_edge) begin
                run_reg <= 1'b1;
                step_reg <= 5'h00;
            end else if (period_start && run_reg) begin
                if ({1'b0, step_reg} == seqlen_reg - 6'h01) begin
                    step_reg <= 5'h00;
                    if (play_reg) begin
                        run_reg <= 1'b0;
                    end
                end else begin
                    step_reg <= step_reg + 5'h01;
                end
            end
        end
    end

    // ****************************************
    // cylinders and factor product
    // ****************************************
    msm_lfsr u_lfsr (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .rnd     (rnd)
    );

    assign acc[0] = {4'h0, `MSM_FP_ONE};

    genvar g;
    generate
        for (g = 0; g < `MSM_PROF_WORDS; g = g + 1) begin : g_prof
            assign prof_flat[g*12 +: 12] = prof_reg[g];
        end
        for (g = 0; g < `MSM_NCYL; g = g + 1) begin : g_cyl
            wire [27:0] mul;
            wire [31:0] tbl;
            assign tbl = cfg_reg[g][`MSM_CFG_SEQTYPE] ? seq_reg[g] : seq_reg[`MSM_COMMON_SEQ];
            assign seq_bits[g] = run_reg & tbl[step_reg];
            assign mul = acc[g] * factor[g];
            assign acc[g+1] = sat16({4'h0, mul[27:10]});
            msm_cyl u_cyl (
                .pclk         (pclk),
                .presetn      (presetn),
                .ce           (ce),
                .period_start (period_start),
                .angle        (angle_in),
                .ref_phase    (ref_reg),
                .cfg          (cfg_reg[g]),
                .prob         (prob_reg[g]),
                .seq_bit      (seq_bits[g]),
                .draw         (rnd[g+15:g]),
                .prof_flat    (prof_flat),
                .active       (cyl_active[g]),
                .factor       (factor[g])
            );
        end
    endgenerate

    assign speed_prod = speed_in * acc[`MSM_NCYL];
    assign speed_sat = sat16(speed_prod[31:10]);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_out <= 16'h0000;
        end else if (ce) begin
            speed_out <= speed_sat;
        end
    end

endmodule // msm_top

// ===== msm_map.vh
`ifndef MSM_MAP_VH
`define MSM_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define MSM_OFF_CTRL      12'h000
`define MSM_OFF_SEQLEN    12'h004
`define MSM_OFF_STATUS    12'h008
`define MSM_OFF_SPEED     12'h00C
`define MSM_PAGE_CFG      6'h01
`define MSM_PAGE_PROB     6'h02
`define MSM_PAGE_SEQ      6'h03
`define MSM_PAGE_PROF     4'h1

// ****************************************
// field positions
// ****************************************
`define MSM_CTRL_PLAY     16
`define MSM_CTRL_TRIG     17
`define MSM_CFG_MODE      12
`define MSM_CFG_SEQTYPE   13
`define MSM_CFG_EN        14
`define MSM_ST_RUN        24

// ****************************************
// counts and reset values
// ****************************************
`define MSM_NCYL          12
`define MSM_NSEQ          13
`define MSM_COMMON_SEQ    4'hC
`define MSM_PROF_WORDS    64
`define MSM_ANG_PERIOD    12'h2D0
`define MSM_ANG_TWICE     12'h5A0
`define MSM_ANG_MAX       10'h2D0
`define MSM_PT_SPAN       12'h02D
`define MSM_FP_ONE        12'h400
`define MSM_FACT_MIN      12'h00A
`define MSM_FACT_MAX      12'h800
`define MSM_ATT_MAX       11'h400
`define MSM_PROB_MAX      14'h2710
`define MSM_SEQLEN_MAX    6'h20
`define MSM_CFG_RST       32'h0400_0000
`define MSM_LFSR_SEED     32'h1ACE_5EED
`define MSM_LFSR_TAPS     32'h8020_0003

`endif

// ===== msm_lfsr.v
`include "msm_map.vh"

// ****************************************
// free running pseudo-random source
// ****************************************
module msm_lfsr (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    output wire [31:0] rnd
);
    reg [31:0] lfsr_reg;
    wire [31:0] lfsr_next;

    assign lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `MSM_LFSR_TAPS) : (lfsr_reg >> 1);
    assign rnd = lfsr_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_reg <= `MSM_LFSR_SEED;
        end else if (ce) begin
            lfsr_reg <= lfsr_next;
        end
    end
endmodule // msm_lfsr

// ===== msm_cyl.v
`include "msm_map.vh"

// ****************************************
// one cylinder: placement, activation, factor
// ****************************************
module msm_cyl (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         ce,
    input  wire         period_start,
    input  wire [9:0]   angle,
    input  wire [9:0]   ref_phase,
    input  wire [31:0]  cfg,
    input  wire [13:0]  prob,
    input  wire         seq_bit,
    input  wire [15:0]  draw,
    input  wire [767:0] prof_flat,
    output reg          active,
    output reg  [11:0]  factor
);
    wire [11:0]        rel0;
    wire [11:0]        rel1;
    wire [11:0]        rel2;
    wire [11:0]        quot;
    wire [5:0]         sel;
    wire [11:0]        point;
    wire [10:0]        att;
    wire signed [12:0] diff;
    wire signed [24:0] prod;
    wire signed [14:0] scaled;
    wire signed [14:0] fsum;
    wire [29:0]        rnd_prod;
    wire [13:0]        rnd;

    // angle relative to start angle plus reference phase, modulo one period
    assign rel0 = {2'b00, angle} + `MSM_ANG_TWICE - {2'b00, cfg[9:0]} - {2'b00, ref_phase};
    assign rel1 = (rel0 >= `MSM_ANG_PERIOD) ? rel0 - `MSM_ANG_PERIOD : rel0;
    assign rel2 = (rel1 >= `MSM_ANG_PERIOD) ? rel1 - `MSM_ANG_PERIOD : rel1;
    assign quot = rel2 / `MSM_PT_SPAN;
    assign sel = {cfg[11:10], quot[3:0]};
    assign point = prof_flat[sel * 12 +: 12];
    assign att = cfg[26:16];
    // factor = 1 + (point - 1) * att
    assign diff = $signed({1'b0, point}) - $signed({1'b0, `MSM_FP_ONE});
    assign prod = diff * $signed({2'b00, att});
    assign scaled = prod[24:10];
    assign fsum = scaled + $signed({3'b000, `MSM_FP_ONE});
    // uniform draw scaled to 0..9999
    assign rnd_prod = draw * `MSM_PROB_MAX;
    assign rnd = rnd_prod[29:16];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= 1'b0;
            factor <= `MSM_FP_ONE;
        end else if (ce) begin
            if (period_start) begin
                if (cfg[`MSM_CFG_MODE]) begin
                    active <= seq_bit;
                end else begin
                    active <= (rnd < prob);
                end
            end
            if (cfg[`MSM_CFG_EN] && active) begin
                factor <= fsum[11:0];
            end else begin
                factor <= `MSM_FP_ONE;
            end
        end
    end
endmodule // msm_cyl

// ===== msm_top_sva.sv
// ****
// port checker
// ****
module msm_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [9:0]  angle_in,
    input wire        angle_valid,
    input wire [15:0] speed_in,
    input wire [15:0] speed_out,
    input wire [11:0] cyl_active,
    input wire        seq_running
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [9:0] last_ang;
    reg  [2:0] age;
    reg        trig_q;
    wire       acc     = psel && penable && pready;
    wire       ctrl_wr = acc && pwrite && paddr == 12'h000;
    wire       trig_wr = ctrl_wr && pwdata[17] && !trig_q;
    wire       ps_c    = angle_valid && ce && angle_in < last_ang;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ang <= 10'h000;
            age      <= 3'h0;
            trig_q   <= 1'b0;
        end else begin
            if (angle_valid && ce) last_ang <= angle_in;
            if (age != 3'h7) age <= age + 3'h1;
            if (ctrl_wr) trig_q <= pwdata[17];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_ce: assert property (pready == ce)
        else $error("pready does not follow ce");
    a_unmapped_err: assert property (
        acc && paddr >= 12'h200 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_active_wrap: assert property (!$stable(cyl_active) |-> $past(ps_c))
        else $error("activation changed outside period start");
    a_status_read: assert property (
        acc && !pwrite && paddr == 12'h008 |->
        prdata[11:0] == $past(cyl_active) && prdata[24] == $past(seq_running))
        else $error("status read wrong");
    a_speed_read: assert property (
        acc && !pwrite && paddr == 12'h00C |->
        prdata == {16'h0000, $past(speed_out)})
        else $error("speed read wrong");
    a_unity_speed: assert property (
        age == 3'h7 && $past(cyl_active) == 12'h0 &&
        $past(cyl_active, 2) == 12'h0 && $past(speed_in) == $past(speed_in, 2)
        |-> speed_out == $past(speed_in))
        else $error("speed changed with no active cylinder");
    a_trig_run: assert property (trig_wr |-> ##[1:2] seq_running)
        else $error("trigger edge did not start playback");
    a_run_cause: assert property (
        $rose(seq_running) |-> $past(trig_wr) || $past(trig_wr, 2))
        else $error("playback started without trigger edge");
    a_stop_wrap: assert property ($fell(seq_running) |-> $past(ps_c))
        else $error("playback stopped outside period start");
endmodule // msm_chk

bind msm_top msm_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .angle_in(angle_in), .angle_valid(angle_valid),
    .speed_in(speed_in), .speed_out(speed_out), .cyl_active(cyl_active),
    .seq_running(seq_running));

// ===== msm_angle_src.sv
// ****
// crank angle source, drops valid every fourth cycle
// ****
module msm_angle_src #(
    parameter int STEP = 5
) (
    input  wire       pclk,
    input  wire       presetn,
    output logic [9:0] angle_in,
    output logic       angle_valid,
    output logic       wrap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] pos;
    logic [1:0] ph;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos <= 10'h000;
            ph <= 2'h0;
            angle_in <= 10'h000;
            angle_valid <= 1'b0;
            wrap <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            wrap <= 1'b0;
            if (ph == 2'h3) begin
                // invalid slot: line shows no stale angle
                angle_valid <= 1'b0;
                angle_in <= ~angle_in;
            end else begin
                angle_valid <= 1'b1;
                angle_in <= pos;
                wrap <= (pos == 10'h000);
                pos <= (pos >= 10'(720 - STEP)) ? 10'h000 : pos + 10'(STEP);
            end
        end
    end
endmodule // msm_angle_src

// ===== testbench.sv
// ****
// register level regression
// ****
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [15:0] speed_in = 16'h1000;
    wire  [31:0] prdata;
    wire         pready, pslverr, angle_valid, wrap, seq_running;
    wire  [9:0]  angle_in;
    wire  [15:0] speed_out;
    wire  [11:0] cyl_active;
    int          err_count = 0, n_tests = 0;
    always #12.5 pclk = ~pclk;
    msm_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .angle_in(angle_in), .angle_valid(angle_valid),
        .speed_in(speed_in), .speed_out(speed_out), .cyl_active(cyl_active),
        .seq_running(seq_running));
    msm_angle_src src (.pclk(pclk), .presetn(presetn), .angle_in(angle_in),
        .angle_valid(angle_valid), .wrap(wrap));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
        check({31'h0, er}, {31'h0, eexp});
    endtask
    // wait n period starts, then let activation and speed settle
    task automatic wrap_wait(input int n);
        repeat (n) begin
            @(posedge pclk);
            while (wrap !== 1'b1) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask
    task automatic state(input logic [11:0] act, input logic [15:0] spd);
        check({20'h0, cyl_active}, {20'h0, act});
        check({16'h0, speed_out}, {16'h0, spd});
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #500000;
        err_count++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rdchk(12'h000, 32'h0, 0);
        rdchk(12'h004, 32'h0000_0020, 0);
        for (int n = 0; n < 13; n++) begin
            rdchk(12'(12'h0C0 + 4 * n), 32'h0, 0);
            if (n < 12) rdchk(12'(12'h040 + 4 * n), 32'h0400_0000, 0);
            if (n < 12) rdchk(12'(12'h080 + 4 * n), 32'h0, 0);
        end
        for (int k = 0; k < 64; k += 9) rdchk(12'(12'h100 + 4 * k), 32'h0000_0400, 0);
        wr(12'h800, 32'hFFFF_FFFF);
        check({31'h0, er}, 32'h1);
        rdchk(12'h800, 32'h0, 1);
        wr(12'h040, 32'h07FF_7FFF);
        rdchk(12'h040, 32'h0400_7ED0, 0);
        for (int p = 0; p < 4; p++) begin
            wr(12'h044, 32'(p) << 10);
            rdchk(12'h044, 32'(p) << 10, 0);
        end
        wr(12'h000, 32'h0000_03FF);
        rdchk(12'h000, 32'h0000_02D0, 0);
        wr(12'h080, 32'h0000_FFFF);
        rdchk(12'h080, 32'h0000_2710, 0);
        wr(12'h104, 32'h0000_0FFF);
        rdchk(12'h104, 32'h0000_0800, 0);
        wr(12'h104, 32'h0);
        rdchk(12'h104, 32'h0000_000A, 0);
        wr(12'h004, 32'h0);
        rdchk(12'h004, 32'h1, 0);
        wr(12'h000, 32'h0);
        wr(12'h080, 32'h0);
        for (int k = 0; k < 16; k++) wr(12'(12'h140 + 4 * k), 32'h0000_0200);
        wr(12'h004, 32'h2);
        wr(12'h040, 32'h0400_7400);
        wr(12'h044, 32'h0400_5400);
        wr(12'h0C0, 32'h1);
        wr(12'h0F0, 32'h2);
        wrap_wait(1);
        wr(12'h000, 32'h0001_0000);
        wr(12'h000, 32'h0003_0000);
        repeat (2) @(posedge pclk);
        rdchk(12'h008, 32'h0100_0000, 0);
        wrap_wait(1);
        state(12'h001, 16'h0800);
        wrap_wait(1);
        state(12'h002, 16'h0800);
        wrap_wait(1);
        state(12'h000, 16'h1000);
        check({31'h0, seq_running}, 32'h0);
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h0002_0000);
        wrap_wait(1);
        state(12'h001, 16'h0800);
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h0002_0000);
        wrap_wait(1);
        state(12'h001, 16'h0800);
        // clock enable low: bus stalls and speed holds although its input moves
        ce <= 0;
        speed_in <= 16'h3000;
        repeat (3) @(posedge pclk);
        check({31'h0, pready}, 32'h0);
        check({16'h0, speed_out}, 32'h0000_0800);
        ce <= 1;
        speed_in <= 16'h1000;
        wrap_wait(1);
        state(12'h002, 16'h0800);
        wrap_wait(1);
        state(12'h001, 16'h0800);
        wr(12'h0C0, 32'h3);
        wr(12'h0C4, 32'h3);
        wr(12'h044, 32'h0400_7400);
        wrap_wait(1);
        state(12'h003, 16'h0400);
        wr(12'h044, 32'h0200_7400);
        repeat (3) @(posedge pclk);
        check({16'h0, speed_out}, 32'h0000_0600);
        wr(12'h044, 32'h0200_3400);
        repeat (3) @(posedge pclk);
        rdchk(12'h00C, 32'h0000_0800, 0);
        wr(12'h040, 32'h0400_4400);
        speed_in <= 16'h2000;
        wrap_wait(1);
        check({31'h0, cyl_active[0]}, 32'h0);
        check({16'h0, speed_out}, 32'h0000_2000);
        wr(12'h080, 32'h0000_2710);
        wrap_wait(1);
        check({31'h0, cyl_active[0]}, 32'h1);
        check({16'h0, speed_out}, 32'h0000_1000);
        wr(12'h0C0, 32'h0);
        wr(12'h040, 32'h0400_7400);
        wrap_wait(1);
        check({31'h0, cyl_active[0]}, 32'h0);
        // profile 2 halved over its first half, placed at start 180 plus phase 180
        for (int k = 0; k < 8; k++) wr(12'(12'h180 + 4 * k), 32'h0000_0200);
        wr(12'h000, 32'h0000_00B4);
        wr(12'h088, 32'h0000_2710);
        wr(12'h048, 32'h0400_48B4);
        wrap_wait(1);
        check({31'h0, cyl_active[2]}, 32'h1);
        check({16'h0, speed_out}, 32'h0000_2000);
        repeat (144) @(posedge pclk);
        check({16'h0, speed_out}, 32'h0000_1000);
        final_report;
    end
endmodule // testbench
